// [inc/clkctl_pkg.sv]
// Functional notes
// R1: Outputs run while off-request pin is low.
// R2: Disabled output parks high, low or high-Z.
// R3: Enabling starts at next leading clock edge.
// R4: Disabling waits for current period to end.
// R5: Spread pin low suppresses all modulation.
// R6: Spread only on first-loop outputs.
// R7: Each loop picks external or crystal reference.
// R8: Each divider picks first or second loop.
// R9: Tuning-voltage outputs come from second loop.
// R10: Software keeps two fast frequencies at most.
// R11: External divider keeps loop input within limit.
// R12: Final divider divides output clock further.
// R13: Crystal load selects 0, 6, 8, 10 pF.
// R14: Pins synchronised before controlling any output.
`default_nettype none
package clkctl_pkg;
   localparam int NUM_OUT = 8;

   // Register byte offsets
   localparam logic [7:0] LOOP_CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF    = 8'h04;
   localparam logic [7:0] OUT_CFG_OFF   = 8'h08;
   localparam logic [7:0] OUT_CFG_END   = 8'h28;

   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // Limits and tables
   localparam logic [6:0] LOOP_IN_MAX_MHZ = 7'h1e;
   localparam logic [2:0] R_EXP_MIN       = 3'h1;
   localparam logic [3:0] LOAD_PF [4]     = '{4'h0, 4'h6, 4'h8, 4'ha};

   typedef enum logic [1:0] {
      PARK_LOW  = 2'b00,
      PARK_HIGH = 2'b01,
      PARK_HIZ  = 2'b10
   } park_t;

   typedef enum logic {
      GATE_OFF = 1'b0,
      GATE_ON  = 1'b1
   } gate_t;

   typedef struct packed {
      logic [16:0] pad;
      logic [6:0]  extFreqMhz;
      logic [3:0]  pad2;
      logic [1:0]  loadCode;
      logic        secondRefExt;
      logic        firstRefExt;
   } loopCtrl_t;

   typedef struct packed {
      logic        invert;
      logic        outEn;
      logic [2:0]  rExp;
      park_t       park;
      logic        spreadEn;
      logic        vcxoPath;
      logic        srcSecond;
   } outCfg_t;

   typedef struct packed {
      logic [7:0]  presentedMhz;
      logic [1:0]  pad;
      logic [1:0]  extDivExp;
      logic [3:0]  loadPf;
      logic [7:0]  spread;
      logic [7:0]  running;
   } status_t;

   typedef struct packed {
      logic        firstRefExt;
      logic        secondRefExt;
      logic [1:0]  extDivExp;
      logic [1:0]  loadCode;
      logic [7:0]  srcSecond;
      logic [7:0]  spread;
   } synthCtrl_t;

   typedef struct packed {
      logic [6:0]  cnt;
      gate_t       st;
      logic        clk;
      logic        oe;
   } gateState_t;

   typedef struct packed {
      logic        s1;
      logic        s2;
   } syncState_t;

   typedef struct packed {
      loopCtrl_t                  lc;
      outCfg_t [NUM_OUT-1:0]      oc;
      logic [31:0]                rdata;
      logic                       wrPend;
      logic [7:0]                 wrAddr;
      synthCtrl_t                 ctl;
   } mainState_t;

   // Values after reset
   localparam logic [31:0] LOOP_CTRL_RST = 32'h0000_1900;
   localparam logic [9:0]  OUT_CFG_RST   = 10'h120;
   localparam gateState_t  GATE_RST      = '{cnt: 7'h00, st: GATE_OFF, clk: 1'h0, oe: 1'h1};
   localparam mainState_t  MAIN_RST      = '{lc: loopCtrl_t'(LOOP_CTRL_RST),
                                             oc: {NUM_OUT{OUT_CFG_RST}},
                                             rdata: 32'h0000_0000,
                                             wrPend: 1'h0,
                                             wrAddr: 8'h00,
                                             ctl: '0};
endpackage
`default_nettype wire

// [hw/sync_two_ff.sv]
`default_nettype none
module sync_two_ff #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic resetn,
   // Asynchronous level in, synchronised level out
   input  wire logic din,
   output logic      dout
);
   import clkctl_pkg::*;

   syncState_t q;
   syncState_t d;

   // First stage feeds only the second stage
   always_comb begin
      d    = q;
      d.s1 = din;
      d.s2 = q.s1;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q <= '{s1: RST_VAL, s2: RST_VAL};
      end else begin
         q <= d;
      end
   end

   assign dout = q.s2;
endmodule
`default_nettype wire

// [hw/output_gate.sv]
`default_nettype none
module output_gate (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                resetn,
   // Synchronised enable and configuration
   input  wire logic                enable,
   input  wire clkctl_pkg::outCfg_t cfg,
   // Output pin and state
   output logic                     outClk,
   output logic                     outOe,
   output logic                     running
);
   import clkctl_pkg::*;

   gateState_t q;
   gateState_t d;
   logic [7:0] period;
   logic [6:0] last;
   logic [6:0] half;
   logic       wrap;

   // R12 final power-of-two divider
   always_comb begin
      period = 8'h01 << ((cfg.rExp < R_EXP_MIN) ? R_EXP_MIN : cfg.rExp);
      last   = 7'(period - 8'h01);
      half   = 7'(period >> 1);
      wrap   = q.cnt >= last;
   end

   // Gate decision only at a period boundary, so no runt pulse
   always_comb begin
      d     = q;
      d.cnt = wrap ? 7'h00 : 7'(q.cnt + 7'h01);
      // R3 R4 boundary-only switching
      if (wrap) begin
         d.st = enable ? GATE_ON : GATE_OFF;
      end
      // R2 park when off
      if (d.st == GATE_ON) begin
         d.clk = (d.cnt < half) ^ cfg.invert;
         d.oe  = 1'b1;
      end else begin
         d.clk = cfg.park == PARK_HIGH;
         d.oe  = cfg.park != PARK_HIZ;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q <= GATE_RST;
      end else begin
         q <= d;
      end
   end

   assign outClk  = q.clk;
   assign outOe   = q.oe;
   assign running = q.st == GATE_ON;

   default clocking dc @(posedge mclk); endclocking
   default disable iff (!resetn);

   start_on_edge_a: assert property ( // R3
      $rose(q.st == GATE_ON) |-> q.cnt == 7'h00 && q.clk == !$past(cfg.invert))
      else $error("output started away from leading edge");
   enable_follow_a: assert property ( // R1
      wrap && enable |=> q.st == GATE_ON)
      else $error("enabled output not driven at boundary");
   full_period_a: assert property ( // R4
      $fell(q.st == GATE_ON) |-> $past(wrap) && !$past(enable))
      else $error("output stopped inside a period");
   park_state_a: assert property ( // R2
      q.st == GATE_OFF |-> q.clk == ($past(cfg.park) == PARK_HIGH)
                        && q.oe == ($past(cfg.park) != PARK_HIZ))
      else $error("disabled output not at park state");
endmodule
`default_nettype wire

// [hw/clock_output_gating_control.sv]
`default_nettype none
module clock_output_gating_control (
   // Clock and reset
   input  wire logic                           mclk,
   input  wire logic                           resetn,
   // AHB-Lite slave
   input  wire logic                           hsel,
   input  wire logic [31:0]                    haddr,
   input  wire logic [1:0]                     htrans,
   input  wire logic                           hwrite,
   input  wire logic [2:0]                     hsize,
   input  wire logic [31:0]                    hwdata,
   input  wire logic                           hready,
   output logic [31:0]                         hrdata,
   output logic                                hreadyout,
   output logic                                hresp,
   // Control pins, asynchronous to mclk
   input  wire logic                           outputsOffRequestPin,
   input  wire logic                           spreadAllowPin,
   // Output clock pins
   output logic [clkctl_pkg::NUM_OUT-1:0]      outClk,
   output logic [clkctl_pkg::NUM_OUT-1:0]      outClkOe,
   // Controls to the loops and dividers
   output clkctl_pkg::synthCtrl_t              synthCtrl
);
   import clkctl_pkg::*;

   mainState_t           q;
   mainState_t           d;
   status_t              status;
   logic                 accept;
   logic                 addrLow;
   logic                 offSync;
   logic                 spreadSync;
   logic [NUM_OUT-1:0]   running;
   logic [NUM_OUT-1:0]   outEnable;
   // Masks below are read only by the checks
   logic [NUM_OUT-1:0]   vcxoMask;
   logic [NUM_OUT-1:0]   srcMask;
   logic [NUM_OUT-1:0]   hizMask;
   logic [NUM_OUT-1:0]   highMask;
   logic [NUM_OUT-1:0]   invMask;
   logic [NUM_OUT-1:0]   spreadMask;

   // Output divider registers occupy one aligned word each
   function automatic logic isOutCfg(input logic [7:0] a);
      return (a >= OUT_CFG_OFF) && (a < OUT_CFG_END) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] cfgIdx(input logic [7:0] a);
      logic [7:0] off;
      off = a - OUT_CFG_OFF;
      return off[4:2];
   endfunction

   // Smallest power-of-two input division that keeps loop input in limit
   function automatic logic [1:0] divExp(input logic [6:0] f);
      if (f <= LOOP_IN_MAX_MHZ) begin
         return 2'h0;
      end else if ((f >> 1) <= LOOP_IN_MAX_MHZ) begin
         return 2'h1;
      end else if ((f >> 2) <= LOOP_IN_MAX_MHZ) begin
         return 2'h2;
      end else begin
         return 2'h3;
      end
   endfunction

   // Register read mux; unmapped words read as zero
   function automatic logic [31:0] readWord(input logic [7:0] a,
                                            input mainState_t s,
                                            input status_t st);
      if (a == LOOP_CTRL_OFF) begin
         return s.lc;
      end else if (a == STATUS_OFF) begin
         return st;
      end else if (isOutCfg(a)) begin
         return {22'h00_0000, s.oc[cfgIdx(a)]};
      end else begin
         return 32'h0000_0000;
      end
   endfunction

   // R14 pin synchronisers
   sync_two_ff #(
      .RST_VAL (1'b1)
   ) uOffSync (
      .mclk    (mclk),
      .resetn  (resetn),
      .din     (outputsOffRequestPin),
      .dout    (offSync)
   );

   sync_two_ff #(
      .RST_VAL (1'b0)
   ) uSpreadSync (
      .mclk    (mclk),
      .resetn  (resetn),
      .din     (spreadAllowPin),
      .dout    (spreadSync)
   );

   // Bus address phase qualifier; both NONSEQ and SEQ are taken
   always_comb begin
      accept  = hsel && hready && htrans[1];
      addrLow = haddr[31:8] == 24'h00_0000;
   end

   // Status word shows the block's live state
   always_comb begin
      status              = '0;
      status.presentedMhz = 8'(q.lc.extFreqMhz >> q.ctl.extDivExp);
      status.extDivExp    = q.ctl.extDivExp;
      // R13 load value table
      status.loadPf       = LOAD_PF[q.ctl.loadCode];
      status.spread       = q.ctl.spread;
      status.running      = running;
   end

   // Next state: write data phase first, so a read right after sees it
   always_comb begin
      d        = q;
      d.wrPend = 1'b0;
      if (q.wrPend) begin
         if (q.wrAddr == LOOP_CTRL_OFF) begin
            d.lc = loopCtrl_t'(hwdata);
         end else if (isOutCfg(q.wrAddr)) begin
            d.oc[cfgIdx(q.wrAddr)] = outCfg_t'(hwdata[9:0]);
         end
      end
      // Reserved bits always read zero
      d.lc.pad  = '0;
      d.lc.pad2 = '0;
      if (accept) begin
         d.wrPend = hwrite && addrLow;
         d.wrAddr = haddr[7:0];
         if (!hwrite) begin
            d.rdata = addrLow ? readWord(haddr[7:0], d, status) : 32'h0000_0000;
         end
      end
      // R7 loop reference select
      d.ctl.firstRefExt  = d.lc.firstRefExt;
      d.ctl.secondRefExt = d.lc.secondRefExt;
      // R11 input divider choice
      d.ctl.extDivExp    = divExp(d.lc.extFreqMhz);
      // R13 crystal load code
      d.ctl.loadCode     = d.lc.loadCode;
      for (int i = 0; i < NUM_OUT; i++) begin
         // R8 R9 divider source
         d.ctl.srcSecond[i] = d.oc[i].srcSecond | d.oc[i].vcxoPath;
         // R5 R6 spread gating
         d.ctl.spread[i] = d.oc[i].spreadEn & ~d.ctl.srcSecond[i] & spreadSync;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         q <= MAIN_RST;
      end else begin
         q <= d;
      end
   end

   // Per-output enable: pin low and output switched on in software
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         // R1 pin low enables
         outEnable[i] = !offSync && q.oc[i].outEn;
      end
   end

   // One glitch-free gate per output
   for (genvar g = 0; g < NUM_OUT; g++) begin : gGate
      output_gate uGate (
         .mclk    (mclk),
         .resetn  (resetn),
         .enable  (outEnable[g]),
         .cfg     (q.oc[g]),
         .outClk  (outClk[g]),
         .outOe   (outClkOe[g]),
         .running (running[g])
      );
   end

   // Zero wait states, always OKAY
   assign hrdata    = q.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign synthCtrl = q.ctl;

   // Helper masks read only by the checks below
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         vcxoMask[i] = q.oc[i].vcxoPath;
         srcMask[i]  = q.oc[i].srcSecond;
         hizMask[i]    = q.oc[i].park == PARK_HIZ;
         highMask[i]   = q.oc[i].park == PARK_HIGH;
         invMask[i]    = q.oc[i].invert;
         spreadMask[i] = q.oc[i].spreadEn;
      end
   end

   default clocking dc @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence lcWrite;
      accept && hwrite && haddr == {24'h00_0000, LOOP_CTRL_OFF} ##1 1'b1;
   endsequence

   sequence spreadLow;
      !spreadAllowPin [*4];
   endsequence

   ref_select_a: assert property ( // R7
      lcWrite |=> {q.ctl.secondRefExt, q.ctl.firstRefExt} == $past(hwdata[1:0]))
      else $error("loop reference select not applied");
   load_cap_a: assert property ( // R13
      lcWrite |=> status.loadPf == LOAD_PF[$past(hwdata[3:2])])
      else $error("crystal load value wrong");
   ext_div_limit_a: assert property ( // R11
      (q.lc.extFreqMhz >> q.ctl.extDivExp) <= LOOP_IN_MAX_MHZ)
      else $error("loop input above limit");
   vcxo_second_a: assert property ( // R9
      (vcxoMask & ~q.ctl.srcSecond) == '0)
      else $error("tuning output not on second loop");
   divider_src_a: assert property ( // R8
      (q.ctl.srcSecond & ~(vcxoMask | srcMask)) == '0)
      else $error("divider source differs from setting");
   spread_first_a: assert property ( // R6
      (q.ctl.spread & q.ctl.srcSecond) == '0)
      else $error("spread on second-loop output");
   spread_pin_a: assert property ( // R5
      spreadLow |-> q.ctl.spread == '0)
      else $error("spread active while pin low");
   pin_sync_a: assert property ( // R14
      $past(resetn, 2) |-> offSync == $past(outputsOffRequestPin, 2))
      else $error("off-request not two stages late");
   spread_sync_a: assert property ( // R14
      $past(resetn, 2) |-> spreadSync == $past(spreadAllowPin, 2))
      else $error("spread pin not two stages late");

   // Gates switch only on the enable seen at the boundary
   run_start_a: assert property ( // R1
      (running & ~$past(running) & ~$past(outEnable)) == '0)
      else $error("output started without enable");
   run_stop_a: assert property ( // R4
      (~running & $past(running) & $past(outEnable)) == '0)
      else $error("output stopped while enabled");
   lead_edge_a: assert property ( // R3
      (running & ~$past(running) & (outClk ^ ~$past(invMask))) == '0)
      else $error("output did not start on leading edge");

   // Park levels follow the setting held before the edge
   park_hiz_a: assert property ( // R2
      (~outClkOe & ~$past(hizMask)) == '0)
      else $error("output released without high-Z park");
   park_high_a: assert property ( // R2
      (~running & outClk & ~$past(highMask)) == '0)
      else $error("stopped output high without high park");

   // Spread only where software asked, never on the tuning path
   spread_request_a: assert property ( // R5
      (synthCtrl.spread & ~spreadMask) == '0)
      else $error("spread on output not set for it");
   spread_vcxo_a: assert property ( // R9
      (synthCtrl.spread & vcxoMask) == '0)
      else $error("spread on tuning-voltage output");

   // Loop controls track the control word; divider is the smallest that fits
   ref_follow_a: assert property ( // R7
      synthCtrl.firstRefExt == q.lc.firstRefExt
      && synthCtrl.secondRefExt == q.lc.secondRefExt)
      else $error("loop reference differs from control word");
   load_table_a: assert property ( // R13
      status.loadPf == LOAD_PF[q.lc.loadCode])
      else $error("load value differs from load code");
   div_minimal_a: assert property ( // R11
      q.ctl.extDivExp == 2'h0
      || (q.lc.extFreqMhz >> (q.ctl.extDivExp - 2'h1)) > LOOP_IN_MAX_MHZ)
      else $error("input divider larger than needed");
   presented_max_a: assert property ( // R11
      status.presentedMhz <= {1'b0, LOOP_IN_MAX_MHZ})
      else $error("presented rate above limit");

   // Readback: a read returns the word standing after its address edge
   sequence lcRead;
      accept && !hwrite && haddr == {24'h00_0000, LOOP_CTRL_OFF} ##1 1'b1;
   endsequence

   sequence cfgRead;
      accept && !hwrite && haddr == {24'h00_0000, OUT_CFG_OFF} ##1 1'b1;
   endsequence

   ctrl_readback_a: assert property ( // R7
      lcRead |-> hrdata == q.lc)
      else $error("loop control read back wrong");
   cfg_readback_a: assert property ( // R8
      cfgRead |-> hrdata == {22'h00_0000, q.oc[0]})
      else $error("divider setting read back wrong");
   rdata_hold_a: assert property ( // R8
      !$past(accept && !hwrite) |-> $stable(hrdata))
      else $error("read data changed without a read");
endmodule
`default_nettype wire

// [test/board_load_model.sv]
`default_nettype none
module board_load_model #(
   parameter int HALF = 2
) (
   // Clock
   input  wire logic mclk,
   // Pins driven by the board
   output logic      offPin,
   output logic      spreadPin,
   // Watched output clock
   input  wire logic loadClk,
   output int        runts
);
   timeunit 1ns;
   timeprecision 1ns;
   int hiLen;

   // Board starts with outputs off and spread allowed
   initial begin
      offPin = 1'h1;
      spreadPin = 1'h1;
      runts = 0;
      hiLen = 0;
   end

   task automatic setPins(input logic off, input logic spr);
      @(posedge mclk);
      offPin <= off;
      spreadPin <= spr;
   endtask

   // whole high halves only, a cut pulse is a runt
   always @(posedge mclk) begin
      if (loadClk === 1'h1) begin
         hiLen <= hiLen + 1;
      end else begin
         if (hiLen != 0 && hiLen != HALF) begin
            runts <= runts + 1;
         end
         hiLen <= 0;
      end
   end
endmodule
`default_nettype wire

// [test/clock_output_gating_control_tb.sv]
`default_nettype none
module clock_output_gating_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import clkctl_pkg::*;
   logic               mclk;
   logic               resetn;
   logic               hsel;
   logic [31:0]        haddr;
   logic [1:0]         htrans;
   logic               hwrite;
   logic [2:0]         hsize;
   logic [31:0]        hwdata;
   logic [31:0]        hrdata;
   logic               hreadyout;
   logic               hresp;
   logic               offPin;
   logic               spreadPin;
   logic [NUM_OUT-1:0] outClk;
   logic [NUM_OUT-1:0] outClkOe;
   synthCtrl_t         synthCtrl;
   int                 runts;
   int                 failures;
   int                 checksDone;
   int                 n;
   int                 rises;
   logic               prev;
   logic [31:0]        rdVal;

   // Input frequency table and expected divide, presented rate, load
   localparam logic [6:0]  FREQ [4] = '{7'h0a, 7'h1f, 7'h40, 7'h64};
   localparam logic [1:0]  EXPV [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
   localparam logic [7:0]  PRES [4] = '{8'h0a, 8'h0f, 8'h10, 8'h19};
   localparam logic [3:0]  LDPF [4] = '{4'h0, 4'h6, 4'h8, 4'ha};
   // Out0 spread first loop, 1 second loop, 2 and 5 tuning path, 3 park high, 4 hi-Z
   // Out6 inverted, out7 park code 3 with divide code 0
   localparam logic [31:0] CFG [8] = '{32'h0000_0144, 32'h0000_0125, 32'h0000_0126,
                                       32'h0000_0128, 32'h0000_0130, 32'h0000_0122,
                                       32'h0000_0320, 32'h0000_0118};

   clock_output_gating_control dut (
      .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .outputsOffRequestPin(offPin), .spreadAllowPin(spreadPin),
      .outClk(outClk), .outClkOe(outClkOe), .synthCtrl(synthCtrl));

   board_load_model #(.HALF(2)) load (
      .mclk(mclk), .offPin(offPin), .spreadPin(spreadPin),
      .loadClk(outClk[0]), .runts(runts));

   // Free-running 10 MHz clock
   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Single word transfer; waits on hready, the watchdog ends a hang
   task automatic xfer(input logic isWr, input logic [31:0] addr, input logic [31:0] wd);
      hsel <= 1'h1;
      htrans <= HTRANS_NONSEQ;
      haddr <= addr;
      hwrite <= isWr;
      do @(posedge mclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'h1);
      rdVal = hrdata;
   endtask

   task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
      xfer(1'h1, addr, wd);
   endtask

   task automatic rd(input logic [31:0] addr, input logic [31:0] exp, input string what);
      xfer(1'h0, addr, 32'h0000_0000);
      check(what, exp, rdVal);
   endtask

   // Look just after the edge so its updates have landed
   task automatic settle();
      @(posedge mclk);
      #1;
   endtask

   task automatic complete_run();
      if (failures == 0 && checksDone > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Watchdog sized well beyond the roughly 130 cycles the tests need
   initial begin
      repeat (4000) @(posedge mclk);
      failures++;
      complete_run();
   end

   initial begin
      failures = 0;
      checksDone = 0;
      resetn = 1'h0;
      hsel = 1'h0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      repeat (8) @(posedge mclk);
      resetn <= 1'h1;
      @(posedge mclk);
      // Register contents after reset
      rd(32'h0000_0000, 32'h0000_1900, "loopCtrl");
      rd(32'h0000_0008, 32'h0000_0120, "outCfg0");
      check("extDivRst", 32'h0, {30'h0, synthCtrl.extDivExp});
      check("busResp", 32'h0000_0002, {30'h0, hreadyout, hresp});
      // Every reference pairing and load code, input divide steps 0 to 2
      for (int i = 0; i < 4; i++) begin
         wr(32'h0000_0000, {17'h0, FREQ[i], 4'h0, i[1:0], i[1:0]});
         rd(32'h0000_0004, {PRES[i], 2'h0, EXPV[i], LDPF[i], 16'h0}, "status");
         check("loopSel", {i[0], i[1], EXPV[i], i[1:0]}, {26'h0, synthCtrl[21:16]});
      end
      // Read-only and unmapped places take no writes
      wr(32'h0000_0004, 32'hffff_ffff);
      rd(32'h0000_0004, {8'h19, 2'h0, 2'h2, 4'ha, 16'h0}, "statusRo");
      wr(32'h0000_0100, 32'hffff_ffff);
      rd(32'h0000_0100, 32'h0000_0000, "unmapped");
      rd(32'h0000_0028, 32'h0000_0000, "pastEnd");
      // all outputs stay far below the fast limit
      for (int i = 0; i < 8; i++) wr(32'(8 + 4 * i), CFG[i]);
      rd(32'h0000_000c, 32'h0000_0125, "outCfg1");
      repeat (20) settle();
      check("srcSecond", 8'b0010_0110, synthCtrl.srcSecond);
      check("spreadOn", 8'h01, synthCtrl.spread);
      check("parked", 5'b01110, {outClk[0], outClkOe[0], outClk[3], outClkOe[3], outClkOe[4]});
      load.setPins(1'h1, 1'h0);
      repeat (4) settle();
      check("spreadOff", 8'h00, synthCtrl.spread);
      load.setPins(1'h1, 1'h1);
      repeat (4) settle();
      check("spreadBack", 8'h01, synthCtrl.spread);
      // Enable: synchronised, then starts on a whole high half
      load.setPins(1'h0, 1'h1);
      n = 0;
      do begin settle(); n++; end while (outClk[0] !== 1'h1 && n < 12);
      check("enDelay", 1'h1, n >= 3 && n <= 8);
      rises = 0;
      for (int k = 0; k < 16; k++) begin
         prev = outClk[0];
         settle();
         if (prev === 1'h0 && outClk[0] === 1'h1) rises++;
      end
      check("rises", 32'd4, rises);
      check("hizDriven", 1'h1, outClkOe[4]);
      rd(32'h0000_0004, {8'h19, 2'h0, 2'h2, 4'ha, 8'h01, 8'hff}, "running");
      // Disable just after a rising edge, the period must complete
      n = 0;
      do begin settle(); n++; end while (outClk[0] !== 1'h1 && n < 12);
      load.setPins(1'h1, 1'h1);
      repeat (12) settle();
      check("reparked", 5'b01110, {outClk[0], outClkOe[0], outClk[3], outClkOe[3], outClkOe[4]});
      check("runts", 32'd0, runts);
      complete_run();
   end
endmodule
`default_nettype wire
